// [data_eeprom_program_control.sv]
// Control logic for the byte-wide data EEPROM and its register.
// Behaviour
// - Wait entered when idle, else after cycle
// - Halt stops at once, abandoning the cycle
// - Read in write mode leaves bus undriven
// - Write in read mode is not latched
// - Reset mid-cycle leaves memory contents undefined
// - Protection blocks external read and rewrite
// - Removing protection erases all memory first
// - One option bit protects both memories
// - Control register at 30h, upper bits zero
// - Latch bit: set by software, cleared hardware
// - Program bit starts, shows, ends the cycle
// - Clearing program bit mid-cycle aborts it
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_ctrl_map.svh"
module data_eeprom_program_control #(
   parameter int ADDR_W = 8,
   parameter int ROW_BYTES = 4,
   parameter int CNT_W = 16,
   parameter int PROG_CYCLES = `EE_PROG_CYCLES
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic [7:0] reg_addr_i,
   input wire eeprom_ctrl_pkg::byte_t reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output eeprom_ctrl_pkg::byte_t reg_rdata_o,
   input wire logic [ADDR_W-1:0] mem_addr_i,
   input wire eeprom_ctrl_pkg::byte_t mem_wdata_i,
   input wire logic mem_wr_i,
   input wire logic mem_rd_i,
   input wire logic mem_ext_i,
   output eeprom_ctrl_pkg::byte_t mem_rdata_o,
   output logic mem_rdata_oe_o,
   input wire logic wait_req_i,
   input wire logic halt_i,
   input wire logic opt_protect_i,
   input wire logic opt_unprotect_i,
   output logic code_protect_o,
   output logic code_erase_o,
   output logic prog_busy_o,
   output logic in_wait_o,
   output logic in_halt_o,
   output logic irq_o
);
   import eeprom_ctrl_pkg::*;

   localparam int RB_W = $clog2(ROW_BYTES); // Byte index width in a row.
   localparam int ROW_W = ADDR_W - RB_W; // Row address width.

   ee_state_e state_ff, nxt_state; // Sequencer state.
   logic pgm_ff, nxt_pgm; // Program cycle bit.
   logic lat_ff, nxt_lat; // Latch access bit.
   logic [RB_W-1:0] idx_ff, nxt_idx; // Latch byte being committed.
   logic [ADDR_W-1:0] ers_ff, nxt_ers; // Erase address.
   logic [ROW_BYTES-1:0] vld_ff, nxt_vld; // Latched byte flags.
   logic [ROW_W-1:0] row_ff, nxt_row; // Row of the latched bytes.
   byte_t dat_ff [ROW_BYTES]; // Write latches.
   byte_t nxt_dat [ROW_BYTES];
   logic oe_ff, nxt_oe; // Read data drive enable.
   byte_t rdata_ff, nxt_rdata; // Register read data.
   logic [2:0] stat_ff, nxt_stat; // Sticky interrupt status.
   logic [2:0] mask_ff, nxt_mask; // Interrupt mask.

   logic csr_wr; // Write to the control/status register.
   logic csr_abort; // Software clears the program bit mid-cycle.
   logic prot_ext; // External access under protection.
   logic lat_wr_ok; // Core write that goes into the latches.
   logic rd_ok; // Core read that is answered.
   logic acc_err; // Access refused for mode or protection.
   logic ev_done, ev_abort; // Cycle end and abandon events.
   logic t_start, t_abort, t_done; // Timer control.
   logic arr_we; // Array write strobe.
   logic [ADDR_W-1:0] arr_waddr; // Array write address.
   byte_t arr_wdata; // Array write data.

   // Access decode for the core and for the external debug path.
   always_comb begin
      csr_wr = reg_wr_i && (reg_addr_i == `EE_CSR_ADDR);
      csr_abort = csr_wr && pgm_ff && !reg_wdata_i[`EE_PGM_BIT];
      prot_ext = opt_protect_i && mem_ext_i;
      lat_wr_ok = mem_wr_i && lat_ff && !pgm_ff && !prot_ext
         && (state_ff == ST_IDLE);
      rd_ok = mem_rd_i && !lat_ff && !prot_ext
         && (state_ff == ST_IDLE);
      acc_err = (mem_rd_i && (lat_ff || prot_ext))
         || (mem_wr_i && (!lat_ff || prot_ext));
   end

   // Sequencer next state. Later branches take priority: software writes
   // beat the normal sequence, option removal beats those, halt beats all.
   always_comb begin
      nxt_state = state_ff;
      nxt_pgm = pgm_ff;
      nxt_lat = lat_ff;
      nxt_idx = idx_ff;
      nxt_ers = ers_ff;
      nxt_vld = vld_ff;
      nxt_row = row_ff;
      nxt_dat = dat_ff;
      t_start = 1'b0;
      t_abort = 1'b0;
      arr_we = 1'b0;
      arr_waddr = {row_ff, idx_ff};
      arr_wdata = dat_ff[idx_ff];
      ev_done = 1'b0;
      ev_abort = 1'b0;
      // Latch capture; the row follows the last write.
      if (lat_wr_ok) begin
         nxt_dat[mem_addr_i[RB_W-1:0]] = mem_wdata_i;
         nxt_vld[mem_addr_i[RB_W-1:0]] = 1'b1;
         nxt_row = mem_addr_i[ADDR_W-1:RB_W];
      end
      case (state_ff)
         ST_IDLE: begin
            // Nothing is running, so wait is entered at once.
            if (wait_req_i) begin
               nxt_state = ST_WAIT;
            end
         end
         ST_COMMIT: begin
            // Copy latched bytes into the array one per cycle.
            arr_we = vld_ff[idx_ff];
            if (idx_ff == RB_W'(ROW_BYTES - 1)) begin
               t_start = 1'b1;
               nxt_state = ST_TIMING;
            end else begin
               nxt_idx = idx_ff + 1'b1;
            end
         end
         ST_TIMING: begin
            // The end clears both bits in the same cycle.
            if (t_done) begin
               nxt_pgm = 1'b0;
               nxt_lat = 1'b0;
               nxt_vld = '0;
               ev_done = 1'b1;
               // A pending wait is taken only once the cycle is over.
               nxt_state = wait_req_i ? ST_WAIT : ST_IDLE;
            end
         end
         ST_WAIT: begin
            if (!wait_req_i) begin
               nxt_state = ST_IDLE;
            end
         end
         ST_ERASE: begin
            // Whole-array erase, one cell per clock.
            arr_we = 1'b1;
            arr_waddr = ers_ff;
            arr_wdata = `EE_ERASED_BYTE;
            if (ers_ff == {ADDR_W{1'b1}}) begin
               nxt_state = ST_IDLE;
            end else begin
               nxt_ers = ers_ff + 1'b1;
            end
         end
         ST_HALT: begin
            if (!halt_i) begin
               nxt_state = ST_IDLE;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
      // Software access to the control bits.
      if (csr_wr) begin
         if (pgm_ff) begin
            // The latch bit cannot be cleared while programming.
            if (csr_abort) begin
               nxt_pgm = 1'b0;
               nxt_vld = '0;
               nxt_state = ST_IDLE;
               t_abort = 1'b1;
               ev_abort = 1'b1;
            end
         end else if (reg_wdata_i[`EE_PGM_BIT] && reg_wdata_i[`EE_LAT_BIT]
               && (state_ff == ST_IDLE) && !wait_req_i) begin
            nxt_pgm = 1'b1;
            nxt_lat = 1'b1;
            nxt_idx = '0;
            nxt_state = ST_COMMIT;
         end else begin
            nxt_lat = reg_wdata_i[`EE_LAT_BIT];
         end
      end
      // Lifting protection wipes the data array before anything else.
      if (opt_unprotect_i) begin
         nxt_state = ST_ERASE;
         nxt_ers = '0;
         nxt_pgm = 1'b0;
         nxt_lat = 1'b0;
         nxt_vld = '0;
         t_abort = 1'b1;
      end
      // Halt stops everything at once; cells being written may be bad.
      if (halt_i) begin
         nxt_state = ST_HALT;
         nxt_pgm = 1'b0;
         nxt_vld = '0;
         t_abort = 1'b1;
         ev_abort = pgm_ff;
      end
   end

   // Register port next values; a status set wins over the read clear.
   always_comb begin
      nxt_oe = rd_ok;
      nxt_mask = mask_ff;
      nxt_stat = stat_ff;
      nxt_rdata = 8'h00;
      if (reg_rd_i) begin
         case (reg_addr_i)
            `EE_CSR_ADDR: begin
               nxt_rdata = {6'h00, lat_ff, pgm_ff};
            end
            `EE_IRQ_STAT_ADDR: begin
               nxt_rdata = {5'h00, stat_ff};
               nxt_stat = 3'h0;
            end
            `EE_IRQ_MASK_ADDR: begin
               nxt_rdata = {5'h00, mask_ff};
            end
            default: begin
               nxt_rdata = 8'h00;
            end
         endcase
      end
      if (reg_wr_i && (reg_addr_i == `EE_IRQ_MASK_ADDR)) begin
         nxt_mask = reg_wdata_i[2:0];
      end
      nxt_stat[`EE_IRQ_DONE_BIT] = nxt_stat[`EE_IRQ_DONE_BIT] | ev_done;
      nxt_stat[`EE_IRQ_ABORT_BIT] = nxt_stat[`EE_IRQ_ABORT_BIT] | ev_abort;
      nxt_stat[`EE_IRQ_ACCERR_BIT] = nxt_stat[`EE_IRQ_ACCERR_BIT]
         | acc_err;
   end

   // State registers. A reset mid-cycle simply drops the cycle, so the
   // cells being written are left in an unknown state.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         state_ff <= ST_IDLE;
         pgm_ff <= 1'b0;
         lat_ff <= 1'b0;
         idx_ff <= '0;
         ers_ff <= '0;
         vld_ff <= '0;
         row_ff <= '0;
         dat_ff <= '{default: 8'h00};
         oe_ff <= 1'b0;
         rdata_ff <= `EE_CSR_RESET;
         stat_ff <= `EE_IRQ_RESET;
         mask_ff <= `EE_IRQ_RESET;
      end else begin
         state_ff <= nxt_state;
         pgm_ff <= nxt_pgm;
         lat_ff <= nxt_lat;
         idx_ff <= nxt_idx;
         ers_ff <= nxt_ers;
         vld_ff <= nxt_vld;
         row_ff <= nxt_row;
         dat_ff <= nxt_dat;
         oe_ff <= nxt_oe;
         rdata_ff <= nxt_rdata;
         stat_ff <= nxt_stat;
         mask_ff <= nxt_mask;
      end
   end

   // Cycle timer; its length is the only programming time source.
   prog_timer #(
      .CNT_W(CNT_W),
      .CYCLES(PROG_CYCLES)
   ) i_prog_timer (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .start_i(t_start),
      .abort_i(t_abort),
      .busy_o(),
      .done_o(t_done)
   );

   // Data array.
   eeprom_array #(
      .ADDR_W(ADDR_W)
   ) i_eeprom_array (
      .mclk_i(mclk_i),
      .wr_en_i(arr_we),
      .wr_addr_i(arr_waddr),
      .wr_data_i(arr_wdata),
      .rd_en_i(rd_ok),
      .rd_addr_i(mem_addr_i),
      .rd_data_o(mem_rdata_o)
   );

   // Outputs. The option bit is passed straight to the code memory.
   assign reg_rdata_o = rdata_ff;
   assign mem_rdata_oe_o = oe_ff;
   assign code_protect_o = opt_protect_i;
   assign code_erase_o = (state_ff == ST_ERASE);
   assign prog_busy_o = pgm_ff;
   assign in_wait_o = (state_ff == ST_WAIT);
   assign in_halt_o = (state_ff == ST_HALT);
   assign irq_o = |(stat_ff & mask_ff);

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   sequence s_quiet;
      !halt_i && !opt_unprotect_i;
   endsequence
   sequence s_cycle_end;
      (state_ff == ST_TIMING) && t_done && !csr_abort;
   endsequence

   property p_wait_idle;
      (state_ff == ST_IDLE) && wait_req_i && !halt_i && !opt_unprotect_i
         |=> in_wait_o;
   endproperty
   a_wait_idle: assert property (p_wait_idle)
      else $error("idle block did not enter wait");

   property p_wait_after;
      (state_ff == ST_COMMIT) && wait_req_i ##0 s_quiet
         |=> !in_wait_o;
   endproperty
   a_wait_after: assert property (p_wait_after)
      else $error("wait entered during programming");

   property p_halt_stop;
      halt_i |=> in_halt_o && !pgm_ff;
   endproperty
   a_halt_stop: assert property (p_halt_stop)
      else $error("halt did not stop the block");

   property p_rd_lat;
      mem_rd_i && lat_ff |=> !mem_rdata_oe_o;
   endproperty
   a_rd_lat: assert property (p_rd_lat)
      else $error("bus driven on read in write mode");

   property p_wr_nolat;
      mem_wr_i && !lat_ff ##0 s_quiet |=> $stable(vld_ff);
   endproperty
   a_wr_nolat: assert property (p_wr_nolat)
      else $error("write latched in read mode");

   property p_protect;
      (mem_rd_i || mem_wr_i) && prot_ext
         |=> !mem_rdata_oe_o && ($stable(vld_ff)
            || $past(halt_i || opt_unprotect_i || (state_ff != ST_IDLE)));
   endproperty
   a_protect: assert property (p_protect)
      else $error("protected access was served");

   property p_unprotect;
      opt_unprotect_i && !halt_i |=> code_erase_o && !pgm_ff;
   endproperty
   a_unprotect: assert property (p_unprotect)
      else $error("erase did not start");

   property p_reserved;
      reg_rd_i && (reg_addr_i == `EE_CSR_ADDR)
         |=> reg_rdata_o[7:2] == 6'h00
            && reg_rdata_o[1:0] == $past({lat_ff, pgm_ff});
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("control register read is wrong");

   property p_cycle_end;
      s_cycle_end ##0 s_quiet |=> !pgm_ff && !lat_ff
         && stat_ff[`EE_IRQ_DONE_BIT];
   endproperty
   a_cycle_end: assert property (p_cycle_end)
      else $error("cycle end did not clear both bits");

   property p_lat_hold;
      csr_wr && pgm_ff && !reg_wdata_i[`EE_LAT_BIT] && !t_done ##0 s_quiet
         |=> lat_ff;
   endproperty
   a_lat_hold: assert property (p_lat_hold)
      else $error("latch bit cleared while programming");

   property p_abort;
      csr_abort ##0 s_quiet |=> !pgm_ff && (state_ff == ST_IDLE)
         && stat_ff[`EE_IRQ_ABORT_BIT];
   endproperty
   a_abort: assert property (p_abort)
      else $error("program bit clear did not abort");
endmodule // data_eeprom_program_control
`default_nettype wire

// [eeprom_array.sv]
// Byte-wide data EEPROM array with one write port and a registered read.
`timescale 1ns/1ps
`default_nettype none
module eeprom_array #(
   parameter int ADDR_W = 8
) (
   input wire logic mclk_i,
   input wire logic wr_en_i,
   input wire logic [ADDR_W-1:0] wr_addr_i,
   input wire eeprom_ctrl_pkg::byte_t wr_data_i,
   input wire logic rd_en_i,
   input wire logic [ADDR_W-1:0] rd_addr_i,
   output eeprom_ctrl_pkg::byte_t rd_data_o
);
   import eeprom_ctrl_pkg::*;

   // The cells keep no reset value, like a real non-volatile array.
   byte_t cell_mem [2**ADDR_W];
   byte_t rd_ff; // Read data register.
   byte_t nxt_rd; // Next read data.

   // Read data only changes on an enabled read, so it holds otherwise.
   always_comb begin
      nxt_rd = rd_ff;
      if (rd_en_i) begin
         nxt_rd = cell_mem[rd_addr_i];
      end
   end

   // Cell write and read register; no reset so the cells map to storage.
   always_ff @(posedge mclk_i) begin
      if (wr_en_i) begin
         cell_mem[wr_addr_i] <= wr_data_i;
      end
      rd_ff <= nxt_rd;
   end

   assign rd_data_o = rd_ff;
endmodule // eeprom_array
`default_nettype wire

// [eeprom_core_model.sv]
// Core-side model that reaches the EEPROM array over the data bus.
`timescale 1ns/1ps
`default_nettype none
module eeprom_core_model #(
   parameter int ADDR_W = 8
) (
   input wire logic mclk_i,
   output logic [ADDR_W-1:0] mem_addr_o,
   output eeprom_ctrl_pkg::byte_t mem_wdata_o,
   output logic mem_wr_o,
   output logic mem_rd_o,
   output logic mem_ext_o,
   input wire eeprom_ctrl_pkg::byte_t mem_rdata_i,
   input wire logic mem_rdata_oe_i
);
   import eeprom_ctrl_pkg::*;
   // The bus starts quiet.
   initial begin
      mem_addr_o = '0;
      mem_wdata_o = 8'h00;
      mem_wr_o = 1'b0;
      mem_rd_o = 1'b0;
      mem_ext_o = 1'b0;
   end
   // One write cycle; the released bus shows the inverse so stale values
   // cannot pass for a held request.
   task automatic write_byte(input logic [ADDR_W-1:0] a, input byte_t d,
                             input logic ext);
      @(posedge mclk_i);
      mem_addr_o <= a;
      mem_wdata_o <= d;
      mem_ext_o <= ext;
      mem_wr_o <= 1'b1;
      @(posedge mclk_i);
      mem_wr_o <= 1'b0;
      mem_ext_o <= 1'b0;
      mem_addr_o <= ~a;
      mem_wdata_o <= ~d;
   endtask
   // One read cycle; drive enable and data are taken one cycle later.
   task automatic read_byte(input logic [ADDR_W-1:0] a, input logic ext,
                            output logic oe, output byte_t d);
      @(posedge mclk_i);
      mem_addr_o <= a;
      mem_ext_o <= ext;
      mem_rd_o <= 1'b1;
      @(posedge mclk_i);
      mem_rd_o <= 1'b0;
      mem_ext_o <= 1'b0;
      mem_addr_o <= ~a;
      @(negedge mclk_i);
      oe = mem_rdata_oe_i;
      d = mem_rdata_i;
   endtask
endmodule // eeprom_core_model
`default_nettype wire

// [eeprom_ctrl_map.svh]
// Register offsets, field positions, reset values and timing of the EEPROM control.
`ifndef EEPROM_CTRL_MAP_SVH
`define EEPROM_CTRL_MAP_SVH

// Register offsets on the register port.
`define EE_CSR_ADDR 8'h30
`define EE_IRQ_STAT_ADDR 8'h31
`define EE_IRQ_MASK_ADDR 8'h32

// Control/status fields and reset value.
`define EE_PGM_BIT 0
`define EE_LAT_BIT 1
`define EE_CSR_RESET 8'h00

// Interrupt status and mask fields.
`define EE_IRQ_DONE_BIT 0
`define EE_IRQ_ABORT_BIT 1
`define EE_IRQ_ACCERR_BIT 2
`define EE_IRQ_RESET 3'h0

// Value left in every cell by a full erase.
`define EE_ERASED_BYTE 8'hff

// Programming time and clock period, both in nanoseconds.
`define EE_PROG_TIME_NS 5000000
`define EE_CLK_PERIOD_NS 100
// Least time, so the cycle count rounds up.
`define EE_PROG_CYCLES \
   ((`EE_PROG_TIME_NS + `EE_CLK_PERIOD_NS - 1) / `EE_CLK_PERIOD_NS)

`endif

// [eeprom_ctrl_pkg.sv]
// Types shared by the EEPROM control modules.
package eeprom_ctrl_pkg;

   // One byte of register or array data.
   typedef logic [7:0] byte_t;

   // Sequencer states of the control block.
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_COMMIT,
      ST_TIMING,
      ST_WAIT,
      ST_ERASE,
      ST_HALT
   } ee_state_e;

endpackage

// [prog_timer.sv]
// Fixed-length timer for one EEPROM programming cycle.
`timescale 1ns/1ps
`default_nettype none
module prog_timer #(
   parameter int CNT_W = 16,
   parameter int CYCLES = 50000
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic abort_i,
   output logic busy_o,
   output logic done_o
);
   logic [CNT_W-1:0] cnt_ff, nxt_cnt; // Elapsed cycles.
   logic busy_ff, nxt_busy; // Timer is running.

   // Abort beats start so a stopped cycle never restarts by accident.
   always_comb begin
      nxt_cnt = cnt_ff;
      nxt_busy = busy_ff;
      done_o = busy_ff && (cnt_ff == CNT_W'(CYCLES - 1));
      if (abort_i) begin
         nxt_busy = 1'b0;
         nxt_cnt = '0;
      end else if (start_i) begin
         nxt_busy = 1'b1;
         nxt_cnt = '0;
      end else if (done_o) begin
         nxt_busy = 1'b0;
      end else if (busy_ff) begin
         nxt_cnt = cnt_ff + 1'b1;
      end
   end

   // Timer registers.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         cnt_ff <= '0;
         busy_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         busy_ff <= nxt_busy;
      end
   end

   assign busy_o = busy_ff;

   // The timer is idle in the cycle after it reports the end.
   property p_done_stops;
      @(posedge mclk_i) disable iff (rst_i)
      done_o && !start_i |=> !busy_o;
   endproperty
   a_done_stops: assert property (p_done_stops)
      else $error("timer still busy after done");
endmodule // prog_timer
`default_nettype wire

// [test_data_eeprom_program_control.sv]
// Self-checking bench for the EEPROM program control block.
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_ctrl_map.svh"
module test_data_eeprom_program_control;
   import eeprom_ctrl_pkg::*;
   // A short timer keeps each programming cycle to a few clocks.
   localparam int PROG = 8;
   logic mclk_i, rst_i, reg_wr, reg_rd, mem_wr, mem_rd, mem_ext, oe;
   logic wait_req, halt, opt_prot, opt_unprot, mem_oe;
   logic code_prot, code_erase, busy, in_wait, in_halt, irq;
   logic [7:0] reg_addr, mem_addr;
   byte_t reg_wdata, reg_rdata, mem_wdata, mem_rdata, rd;
   int n_fail, checks, n;

   data_eeprom_program_control #(.PROG_CYCLES(PROG))
      i_data_eeprom_program_control (
      .mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(reg_addr),
      .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
      .reg_rdata_o(reg_rdata), .mem_addr_i(mem_addr),
      .mem_wdata_i(mem_wdata), .mem_wr_i(mem_wr), .mem_rd_i(mem_rd),
      .mem_ext_i(mem_ext), .mem_rdata_o(mem_rdata),
      .mem_rdata_oe_o(mem_oe), .wait_req_i(wait_req), .halt_i(halt),
      .opt_protect_i(opt_prot), .opt_unprotect_i(opt_unprot),
      .code_protect_o(code_prot), .code_erase_o(code_erase),
      .prog_busy_o(busy), .in_wait_o(in_wait), .in_halt_o(in_halt),
      .irq_o(irq));

   eeprom_core_model i_eeprom_core_model (
      .mclk_i(mclk_i), .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata),
      .mem_wr_o(mem_wr), .mem_rd_o(mem_rd), .mem_ext_o(mem_ext),
      .mem_rdata_i(mem_rdata), .mem_rdata_oe_i(mem_oe));

   // The 10 MHz clock.
   initial begin
      mclk_i = 1'b0;
      forever #50 mclk_i = ~mclk_i;
   end

   // Prints the verdict and stops.
   task automatic complete_run();
      if (n_fail == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Compares one value and counts it.
   task automatic chk(input string nm, input logic [15:0] e, g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tick(input int c);
      repeat (c) @(posedge mclk_i);
   endtask
   task automatic reg_write(input logic [7:0] a, input byte_t d);
      @(posedge mclk_i);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk_i);
      reg_wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe.
   task automatic expect_reg(input string nm, input logic [7:0] a,
                             input byte_t e);
      @(posedge mclk_i);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk_i);
      reg_rd <= 1'b0;
      @(negedge mclk_i);
      chk(nm, {8'h00, e}, {8'h00, reg_rdata});
   endtask
   // Counts cycles a flag stays high; a hang ends the run as a failure.
   task automatic count_high(input bit er, output int c);
      c = 0;
      @(negedge mclk_i);
      while ((er ? code_erase : busy) === 1'b1) begin
         c++;
         if (c > 400) begin
            n_fail++;
            $display("ERROR count_high expected below 400 seen %0d", c);
            complete_run();
         end
         @(negedge mclk_i);
      end
   endtask
   // Enters write mode, latches a row and starts programming.
   task automatic start_row(input logic [7:0] b);
      reg_write(`EE_CSR_ADDR, 8'h02);
      for (int i = 0; i < 4; i++) begin
         i_eeprom_core_model.write_byte(b + 8'(i), 8'ha0 + 8'(i), 1'b0);
      end
      reg_write(`EE_CSR_ADDR, 8'h03);
   endtask

   task automatic t_regs();
      expect_reg("csr", `EE_CSR_ADDR, 8'h00);
      expect_reg("stat", `EE_IRQ_STAT_ADDR, 8'h00);
      expect_reg("mask", `EE_IRQ_MASK_ADDR, 8'h00);
      expect_reg("unmapped", 8'h40, 8'h00);
      reg_write(`EE_CSR_ADDR, 8'hfe);
      expect_reg("csr_rsvd", `EE_CSR_ADDR, 8'h02);
      reg_write(`EE_CSR_ADDR, 8'h00);
      expect_reg("csr_lat_clr", `EE_CSR_ADDR, 8'h00);
   endtask
   task automatic t_erase();
      @(posedge mclk_i);
      opt_unprot <= 1'b1;
      @(posedge mclk_i);
      opt_unprot <= 1'b0;
      count_high(1'b1, n);
      chk("erase_len", 16'd256, 16'(n));
      i_eeprom_core_model.read_byte(8'h37, 1'b0, oe, rd);
      chk("erase_cell", 16'h00ff, {8'h00, rd});
   endtask
   task automatic t_program();
      reg_write(`EE_IRQ_MASK_ADDR, 8'h07);
      start_row(8'h20);
      count_high(1'b0, n);
      // One commit cycle per latched byte of the row, then the timer.
      chk("prog_len", 16'(PROG + 4), 16'(n));
      expect_reg("csr_end", `EE_CSR_ADDR, 8'h00);
      chk("irq_done", 16'h1, {15'h0, irq});
      expect_reg("stat_done", `EE_IRQ_STAT_ADDR, 8'h01);
      chk("irq_clr", 16'h0, {15'h0, irq});
      for (int i = 0; i < 4; i++) begin
         i_eeprom_core_model.read_byte(8'h20 + 8'(i), 1'b0, oe, rd);
         chk("prog_cell", {8'h00, 8'ha0 + 8'(i)}, {8'h00, rd});
      end
      reg_write(`EE_IRQ_MASK_ADDR, 8'h00);
   endtask
   task automatic t_modes();
      i_eeprom_core_model.write_byte(8'h10, 8'h55, 1'b0);
      @(negedge mclk_i);
      chk("irq_masked", 16'h0, {15'h0, irq});
      expect_reg("stat_wr", `EE_IRQ_STAT_ADDR, 8'h04);
      i_eeprom_core_model.read_byte(8'h10, 1'b0, oe, rd);
      chk("rd_cell", 16'h00ff, {8'h00, rd});
      reg_write(`EE_CSR_ADDR, 8'h02);
      i_eeprom_core_model.read_byte(8'h10, 1'b0, oe, rd);
      chk("rd_wmode_oe", 16'h0, {15'h0, oe});
      expect_reg("stat_rd", `EE_IRQ_STAT_ADDR, 8'h04);
      reg_write(`EE_CSR_ADDR, 8'h00);
   endtask
   task automatic t_abort();
      start_row(8'h40);
      expect_reg("csr_busy", `EE_CSR_ADDR, 8'h03);
      reg_write(`EE_CSR_ADDR, 8'h00);
      @(negedge mclk_i);
      chk("abort_busy", 16'h0, {15'h0, busy});
      expect_reg("csr_abort", `EE_CSR_ADDR, 8'h02);
      expect_reg("stat_abort", `EE_IRQ_STAT_ADDR, 8'h02);
      reg_write(`EE_CSR_ADDR, 8'h00);
   endtask
   task automatic t_wait();
      @(posedge mclk_i);
      wait_req <= 1'b1;
      @(posedge mclk_i);
      @(negedge mclk_i);
      chk("wait_idle", 16'h1, {15'h0, in_wait});
      @(posedge mclk_i);
      wait_req <= 1'b0;
      tick(2);
      start_row(8'h60);
      @(posedge mclk_i);
      wait_req <= 1'b1;
      @(negedge mclk_i);
      chk("wait_busy", 16'h0, {15'h0, in_wait});
      count_high(1'b0, n);
      @(posedge mclk_i);
      @(negedge mclk_i);
      chk("wait_after", 16'h1, {15'h0, in_wait});
      @(posedge mclk_i);
      wait_req <= 1'b0;
      tick(2);
      expect_reg("stat_wait", `EE_IRQ_STAT_ADDR, 8'h01);
   endtask
   task automatic t_halt();
      start_row(8'h80);
      tick(2);
      @(posedge mclk_i);
      halt <= 1'b1;
      @(posedge mclk_i);
      @(negedge mclk_i);
      chk("halt_in", 16'h1, {15'h0, in_halt});
      chk("halt_busy", 16'h0, {15'h0, busy});
      @(posedge mclk_i);
      halt <= 1'b0;
      tick(2);
      expect_reg("stat_halt", `EE_IRQ_STAT_ADDR, 8'h02);
      reg_write(`EE_CSR_ADDR, 8'h00);
   endtask
   task automatic t_protect();
      @(posedge mclk_i);
      opt_prot <= 1'b1;
      @(negedge mclk_i);
      chk("code_prot", 16'h1, {15'h0, code_prot});
      i_eeprom_core_model.read_byte(8'h37, 1'b1, oe, rd);
      chk("ext_rd_oe", 16'h0, {15'h0, oe});
      i_eeprom_core_model.read_byte(8'h37, 1'b0, oe, rd);
      chk("int_rd_oe", 16'h1, {15'h0, oe});
      expect_reg("stat_ext_rd", `EE_IRQ_STAT_ADDR, 8'h04);
      reg_write(`EE_CSR_ADDR, 8'h02);
      i_eeprom_core_model.write_byte(8'h37, 8'h00, 1'b1);
      expect_reg("stat_ext_wr", `EE_IRQ_STAT_ADDR, 8'h04);
      reg_write(`EE_CSR_ADDR, 8'h00);
      @(posedge mclk_i);
      opt_prot <= 1'b0;
   endtask
   task automatic t_reset_mid();
      start_row(8'ha0);
      tick(2);
      @(posedge mclk_i);
      rst_i <= 1'b1;
      tick(2);
      rst_i <= 1'b0;
      @(negedge mclk_i);
      chk("rst_busy", 16'h0, {15'h0, busy});
      expect_reg("rst_csr", `EE_CSR_ADDR, 8'h00);
   endtask

   // Main sequence: reset for four cycles, then every scenario in turn.
   initial begin
      n_fail = 0;
      checks = 0;
      rst_i = 1'b1;
      {reg_wr, reg_rd, wait_req, halt, opt_prot, opt_unprot} = '0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      tick(4);
      rst_i <= 1'b0;
      t_regs();
      t_erase();
      t_program();
      t_modes();
      t_abort();
      t_wait();
      t_halt();
      t_protect();
      t_reset_mid();
      complete_run();
   end
endmodule // test_data_eeprom_program_control
`default_nettype wire
